//--- shared/io_capture_pkg.sv
// Constants, register map and field layout of the I/O input capture path
//
// Summary of operation
// - Each of two input paths selects raw pin or storage element output.
// - Storage element is a rising-edge flip-flop or a level-sensitive latch.
// - Basic latch passes data while its clock is high, holds while low.
// - Inverted clock sense selectable; latch and flop combine within one cell.
// - One shared clock enable, routed to input element, output element, or both.
// - Shared clock enable has no inversion and acts like a logic cell enable.
// - Unconnected enable reads asserted; deasserted enable holds output in either mode.
// - Power-up or global set/reset forces the configured initial value, reset by default.
// - Basic cell has one optional delay stage, inserted by default, bypassable.
// - Extended cell offers full delay by default, medium delay, or none.
// - Extended cell adds a fast-capture latch clocked by the output clock.
// - Fast-capture option one: transparent-low latch feeding rising-edge flip-flop.
// - Fast-capture option two: transparent-low latch feeding transparent-high latch.
// - Every clock of the fast-capture arrangements accepts an in-cell inversion.
// - With fast-capture latch in use and no explicit delay, delay is medium.
package io_capture_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] CONFIG_OFFSET = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
	localparam logic [31:0] CONFIG_RESET  = 32'h0000_3030;

	// ****************************************
	// Configuration fields
	// ****************************************
	localparam int FIRST_REGISTERED_BIT  = 0;
	localparam int SECOND_REGISTERED_BIT = 1;
	localparam int ELEMENT_LATCH_BIT     = 2;
	localparam int INPUT_CLOCK_INV_BIT   = 3;
	localparam int ENABLE_INPUT_BIT      = 4;
	localparam int ENABLE_OUTPUT_BIT     = 5;
	localparam int INIT_SET_BIT          = 6;
	localparam int DELAY_LSB             = 7;
	localparam int DELAY_EXPLICIT_BIT    = 9;
	localparam int FAST_LATCH_BIT        = 10;
	localparam int FAST_CLOCK_INV_BIT    = 11;
	localparam int EXTENDED_BIT          = 12;
	localparam int ENABLE_CONNECTED_BIT  = 13;
	localparam int CONFIG_WIDTH          = 14;

	// ****************************************
	// Status fields
	// ****************************************
	localparam int STATUS_DELAYED_BIT = 0;
	localparam int STATUS_FAST_BIT    = 1;
	localparam int STATUS_STORE_BIT   = 2;
	localparam int STATUS_FIRST_BIT   = 3;
	localparam int STATUS_SECOND_BIT  = 4;
	localparam int STATUS_DELAY_LSB   = 5;

	// ****************************************
	// Delay settings
	// ****************************************
	localparam logic [1:0] FULL_DELAY          = 2'h0;
	localparam logic [1:0] MEDIUM_INPUT_DELAY  = 2'h1;
	localparam logic [1:0] NO_INPUT_DELAY      = 2'h2;

	// ****************************************
	// Bus encodings
	// ****************************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

endpackage

//--- rtl/capture_element.sv
// One input storage element: flip-flop or latch with clock sense, enable and initial value
`timescale 1ns/10ps
module capture_element (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clock_level,
	input  wire logic clock_invert,
	input  wire logic latch_mode,
	input  wire logic enable,
	input  wire logic init_set,
	input  wire logic force_init,
	input  wire logic d,
	output logic      q
);

	// ****************************************
	// Clock sense and load decision
	// ****************************************
	logic effective_clock;
	logic previous_clock;
	logic rising;
	logic load;
	logic next_q;

	assign effective_clock = clock_level ^ clock_invert;
	assign rising          = effective_clock & ~previous_clock;
	assign load            = enable & (latch_mode ? effective_clock : rising);
	assign next_q          = force_init ? init_set : (load ? d : q);

	// ****************************************
	// Storage
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			previous_clock <= 1'h0;
			q              <= 1'h0;
		end else begin
			previous_clock <= effective_clock;
			q              <= next_q;
		end
	end

endmodule // capture_element

//--- rtl/io_input_capture_path.sv
// Input capture path of a programmable I/O cell with AHB-Lite configuration registers
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
module io_input_capture_path (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        PAD_IN,
	input  wire logic        INPUT_CLOCK,
	input  wire logic        OUTPUT_CLOCK,
	input  wire logic        LOGIC_CELL_CLOCK_ENABLE,
	input  wire logic        GLOBAL_SET_RESET,
	output logic             INPUT_PATH_FIRST,
	output logic             INPUT_PATH_SECOND,
	output logic             OUTPUT_ELEMENT_ENABLE
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [1:0] effective_delay(input logic [io_capture_pkg::CONFIG_WIDTH-1:0] cfg);
		logic [1:0] chosen;
		chosen = cfg[io_capture_pkg::DELAY_LSB +: 2];
		if (!cfg[io_capture_pkg::EXTENDED_BIT]) begin
			effective_delay = (chosen == io_capture_pkg::NO_INPUT_DELAY) ?
				io_capture_pkg::NO_INPUT_DELAY : io_capture_pkg::FULL_DELAY;
		end else if (cfg[io_capture_pkg::FAST_LATCH_BIT] && !cfg[io_capture_pkg::DELAY_EXPLICIT_BIT]) begin
			effective_delay = io_capture_pkg::MEDIUM_INPUT_DELAY;
		end else if (chosen == io_capture_pkg::MEDIUM_INPUT_DELAY || chosen == io_capture_pkg::NO_INPUT_DELAY) begin
			effective_delay = chosen;
		end else begin
			effective_delay = io_capture_pkg::FULL_DELAY;
		end
	endfunction

	// ****************************************
	// Bus address phase capture
	// ****************************************
	logic [io_capture_pkg::CONFIG_WIDTH-1:0] config_bits;
	logic [io_capture_pkg::CONFIG_WIDTH-1:0] next_config;
	logic                                    write_pending;
	logic [31:0]                             pending_address;
	logic                                    address_phase;
	logic                                    config_write;
	logic [31:0]                             read_value;
	logic [31:0]                             status_value;

	assign address_phase = HSEL & HREADY & HTRANS[1];
	assign config_write  = write_pending & (pending_address == io_capture_pkg::CONFIG_OFFSET);
	assign next_config   = config_write ? HWDATA[io_capture_pkg::CONFIG_WIDTH-1:0] : config_bits;

	always_ff @(posedge CLK) begin
		if (RST) begin
			write_pending   <= 1'h0;
			pending_address <= 32'h0000_0000;
			config_bits     <= io_capture_pkg::CONFIG_RESET[io_capture_pkg::CONFIG_WIDTH-1:0];
			HRDATA          <= 32'h0000_0000;
			HREADYOUT       <= 1'h1;
			HRESP           <= io_capture_pkg::HRESP_OKAY;
		end else begin
			write_pending   <= address_phase & HWRITE;
			pending_address <= {HADDR[31:2], 2'h0};
			config_bits     <= next_config;
			HREADYOUT       <= 1'h1;
			HRESP           <= io_capture_pkg::HRESP_OKAY;
			if (address_phase && !HWRITE) begin
				HRDATA <= read_value;
			end
		end
	end

	// ****************************************
	// Configuration decode
	// ****************************************
	logic       latch_mode;
	logic       enable_level;
	logic       input_enable;
	logic       fast_in_use;
	logic [1:0] delay_setting;

	assign latch_mode    = config_bits[io_capture_pkg::ELEMENT_LATCH_BIT];
	assign enable_level  = config_bits[io_capture_pkg::ENABLE_CONNECTED_BIT] ?
		LOGIC_CELL_CLOCK_ENABLE : 1'h1;
	assign input_enable  = enable_level | ~config_bits[io_capture_pkg::ENABLE_INPUT_BIT];
	assign fast_in_use   = config_bits[io_capture_pkg::FAST_LATCH_BIT] & config_bits[io_capture_pkg::EXTENDED_BIT];
	assign delay_setting = effective_delay(config_bits);

	// ****************************************
	// Data delay taps
	// ****************************************
	logic [1:0] delay_taps;
	logic       delayed_pad;

	always_ff @(posedge CLK) begin
		if (RST) begin
			delay_taps <= 2'h0;
		end else begin
			delay_taps <= {delay_taps[0], PAD_IN};
		end
	end

	assign delayed_pad = (delay_setting == io_capture_pkg::NO_INPUT_DELAY) ? PAD_IN :
		(delay_setting == io_capture_pkg::MEDIUM_INPUT_DELAY) ? delay_taps[0] : delay_taps[1];

	// ****************************************
	// Storage elements
	// ****************************************
	logic force_init;
	logic fast_q;
	logic store_q;
	logic store_d;

	assign force_init = GLOBAL_SET_RESET;
	assign store_d    = fast_in_use ? fast_q : delayed_pad;

	// Fast-capture latch, transparent while the output clock is low
	capture_element fast_latch (
		.clk          (CLK),
		.rst          (RST),
		.clock_level  (OUTPUT_CLOCK),
		.clock_invert (~config_bits[io_capture_pkg::FAST_CLOCK_INV_BIT]),
		.latch_mode   (1'h1),
		.enable       (1'h1),
		.init_set     (config_bits[io_capture_pkg::INIT_SET_BIT]),
		.force_init   (force_init),
		.d            (delayed_pad),
		.q            (fast_q)
	);

	// Input flip-flop or latch on the input clock
	capture_element store_element (
		.clk          (CLK),
		.rst          (RST),
		.clock_level  (INPUT_CLOCK),
		.clock_invert (config_bits[io_capture_pkg::INPUT_CLOCK_INV_BIT]),
		.latch_mode   (latch_mode),
		.enable       (input_enable),
		.init_set     (config_bits[io_capture_pkg::INIT_SET_BIT]),
		.force_init   (force_init),
		.d            (store_d),
		.q            (store_q)
	);

	// ****************************************
	// Input paths and shared enable
	// ****************************************
	logic next_first;
	logic next_second;
	logic next_output_enable;

	assign next_first         = config_bits[io_capture_pkg::FIRST_REGISTERED_BIT] ? store_q : PAD_IN;
	assign next_second        = config_bits[io_capture_pkg::SECOND_REGISTERED_BIT] ? store_q : PAD_IN;
	assign next_output_enable = enable_level | ~config_bits[io_capture_pkg::ENABLE_OUTPUT_BIT];

	always_ff @(posedge CLK) begin
		if (RST) begin
			INPUT_PATH_FIRST      <= 1'h0;
			INPUT_PATH_SECOND     <= 1'h0;
			OUTPUT_ELEMENT_ENABLE <= 1'h1;
		end else begin
			INPUT_PATH_FIRST      <= next_first;
			INPUT_PATH_SECOND     <= next_second;
			OUTPUT_ELEMENT_ENABLE <= next_output_enable;
		end
	end

	// ****************************************
	// Read data selection
	// ****************************************
	logic [1:0] status_delay;
	logic       read_config;
	logic       read_status;

	assign status_delay = effective_delay(next_config);
	assign status_value = {25'h0000000, status_delay, INPUT_PATH_SECOND, INPUT_PATH_FIRST, store_q, fast_q, delayed_pad};
	assign read_config  = ({HADDR[31:2], 2'h0} == io_capture_pkg::CONFIG_OFFSET);
	assign read_status  = ({HADDR[31:2], 2'h0} == io_capture_pkg::STATUS_OFFSET);
	assign read_value   = read_config ? {{(32-io_capture_pkg::CONFIG_WIDTH){1'b0}}, next_config} :
		(read_status ? status_value : 32'h0000_0000);

endmodule // io_input_capture_path

//--- verif/io_capture_monitor.sv
// Port assertions for the input capture path
`timescale 1ns/10ps
module io_capture_monitor (
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic [31:0] HWDATA,
	input wire logic        HREADY,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        PAD_IN,
	input wire logic        LOGIC_CELL_CLOCK_ENABLE,
	input wire logic        GLOBAL_SET_RESET,
	input wire logic        INPUT_PATH_FIRST,
	input wire logic        INPUT_PATH_SECOND,
	input wire logic        OUTPUT_ELEMENT_ENABLE
);
	// ****************************************
	// Configuration mirror and hold counter
	// ****************************************
	logic [13:0] cfg;
	logic        wr_ph;
	logic [2:0]  hold;
	wire         held = cfg[0] && cfg[4] && cfg[13] && !LOGIC_CELL_CLOCK_ENABLE && !GLOBAL_SET_RESET;
	wire         take = HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[31:2] == 30'h0;
	always_ff @(posedge CLK) begin
		if (RST) begin
			cfg <= io_capture_pkg::CONFIG_RESET[13:0];
			wr_ph <= 1'b0;
			hold <= 3'h0;
		end else begin
			wr_ph <= take;
			if (wr_ph)
				cfg <= HWDATA[13:0];
			hold <= held ? hold + {2'h0, hold != 3'h7} : 3'h0;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_ready_high: assert property (HREADYOUT) else $error("hreadyout low");
	a_resp_okay: assert property (!HRESP) else $error("hresp not okay");
	a_raw_first:
		assert property (!$past(RST) && !$past(cfg[0]) |-> INPUT_PATH_FIRST == $past(PAD_IN)) else $error("raw first");
	a_raw_second:
		assert property (!$past(RST) && !$past(cfg[1]) |-> INPUT_PATH_SECOND == $past(PAD_IN)) else $error("raw second");
	a_out_enable:
		assert property (!$past(RST) |-> OUTPUT_ELEMENT_ENABLE ==
			!($past(cfg[5]) && $past(cfg[13]) && !$past(LOGIC_CELL_CLOCK_ENABLE))) else $error("output enable");
	a_init_first:
		assert property (!$past(RST, 2) && $past(GLOBAL_SET_RESET, 2) && $past(GLOBAL_SET_RESET) && $past(cfg[0])
			|-> INPUT_PATH_FIRST == $past(cfg[6])) else $error("init first");
	a_init_second:
		assert property (!$past(RST, 2) && $past(GLOBAL_SET_RESET, 2) && $past(GLOBAL_SET_RESET) && $past(cfg[1])
			|-> INPUT_PATH_SECOND == $past(cfg[6])) else $error("init second");
	a_enable_hold: assert property (hold >= 3'h3 |-> $stable(INPUT_PATH_FIRST)) else $error("hold");
endmodule // io_capture_monitor
bind io_input_capture_path io_capture_monitor mon (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
	.HREADY, .HREADYOUT, .HRESP, .PAD_IN, .LOGIC_CELL_CLOCK_ENABLE, .GLOBAL_SET_RESET, .INPUT_PATH_FIRST,
	.INPUT_PATH_SECOND, .OUTPUT_ELEMENT_ENABLE);

//--- verif/pad_source_model.sv
// Model of the outside source of pad data and of both clock copies
`timescale 1ns/10ps
module pad_source_model (
	input  wire logic clk,
	input  wire logic clock_src,
	input  wire logic data_src,
	output logic      pad = 1'b0,
	output logic      early_clock = 1'b0,
	output logic      late_clock = 1'b0
);
	// One source feeds the early copy and, a cycle later, the low-skew copy
	always @(posedge clk) begin
		pad <= data_src;
		early_clock <= clock_src;
		late_clock <= early_clock;
	end
endmodule // pad_source_model

//--- verif/io_input_capture_path_test.sv
// Self-checking bench for the input capture path
`timescale 1ns/10ps
module io_input_capture_path_test;
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic        HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0]  HTRANS = 2'h0;
	logic        HWRITE = 1'b0;
	logic [2:0]  HSIZE = 3'h2;
	logic [31:0] HWDATA = 32'h0;
	logic        LOGIC_CELL_CLOCK_ENABLE = 1'b0;
	logic        GLOBAL_SET_RESET = 1'b0;
	logic        clk_src = 1'b0;
	logic        pad_src = 1'b0;
	logic [31:0] HRDATA, rd;
	logic        HREADY, HREADYOUT, HRESP, PAD_IN, INPUT_CLOCK, OUTPUT_CLOCK;
	logic        INPUT_PATH_FIRST, INPUT_PATH_SECOND, OUTPUT_ELEMENT_ENABLE;
	int          err_total = 0;
	int          num_checks = 0;
	assign HREADY = HREADYOUT;
	always #5 CLK = ~CLK;
	pad_source_model src (.clk(CLK), .clock_src(clk_src), .data_src(pad_src), .pad(PAD_IN),
		.early_clock(OUTPUT_CLOCK), .late_clock(INPUT_CLOCK));
	io_input_capture_path uut (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY, .HRDATA,
		.HREADYOUT, .HRESP, .PAD_IN, .INPUT_CLOCK, .OUTPUT_CLOCK, .LOGIC_CELL_CLOCK_ENABLE, .GLOBAL_SET_RESET,
		.INPUT_PATH_FIRST, .INPUT_PATH_SECOND, .OUTPUT_ELEMENT_ENABLE);
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= io_capture_pkg::HTRANS_NONSEQ;
		HADDR <= a;
		HWRITE <= wr;
		@(posedge CLK);
		while (HREADY !== 1'b1) @(posedge CLK);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		@(posedge CLK);
		while (HREADY !== 1'b1) @(posedge CLK);
		rd = HRDATA;
	endtask
	task automatic drive(input logic p, input logic c, input logic e1, input logic e2);
		pad_src <= p;
		clk_src <= c;
		repeat (8) @(posedge CLK);
		check({31'h0, INPUT_PATH_FIRST}, {31'h0, e1});
		check({31'h0, INPUT_PATH_SECOND}, {31'h0, e2});
	endtask
	task automatic global_set_reset;
		GLOBAL_SET_RESET <= 1'b1;
		repeat (3) @(posedge CLK);
		GLOBAL_SET_RESET <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs;
		bus(1'b0, 32'h0, 32'h0);
		check(rd, io_capture_pkg::CONFIG_RESET);
		bus(1'b1, 32'h0, 32'hffffffff);
		bus(1'b0, 32'h0, 32'h0);
		check(rd, 32'h3fff);
		bus(1'b1, 32'h8, 32'hffffffff);
		bus(1'b0, 32'h8, 32'h0);
		check(rd, 32'h0);
		$display("registers done");
	endtask
	task automatic test_modes;
		logic [31:0] w;
		logic        x;
		for (logic [3:0] m = 4'h0; m < 4'h8; m++) begin
			w = 32'h1303 | {20'h0, m[1], m[2], 6'h0, m[1], m[0], 2'h0};
			x = m[2] | !m[0];
			bus(1'b1, 32'h0, w);
			pad_src <= 1'b0;
			clk_src <= m[1];
			repeat (8) @(posedge CLK);
			global_set_reset;
			drive(1'b1, m[1], 1'b0, 1'b0);
			drive(1'b1, !m[1], 1'b1, 1'b1);
			drive(1'b0, !m[1], x, x);
			drive(1'b0, m[1], x, x);
			drive(1'b0, !m[1], 1'b0, 1'b0);
		end
		$display("modes done");
	endtask
	task automatic test_enable;
		bus(1'b1, 32'h0, 32'h3331);
		pad_src <= 1'b1;
		clk_src <= 1'b0;
		global_set_reset;
		check({31'h0, OUTPUT_ELEMENT_ENABLE}, 32'h0);
		drive(1'b1, 1'b1, 1'b0, 1'b1);
		drive(1'b1, 1'b0, 1'b0, 1'b1);
		LOGIC_CELL_CLOCK_ENABLE <= 1'b1;
		drive(1'b1, 1'b1, 1'b1, 1'b1);
		check({31'h0, OUTPUT_ELEMENT_ENABLE}, 32'h1);
		bus(1'b1, 32'h0, 32'h1341);
		global_set_reset;
		check({31'h0, INPUT_PATH_FIRST}, 32'h1);
		$display("enable and init done");
	endtask
	task automatic test_delay;
		logic [31:0] cfgs [6] = '{32'h1305, 32'h1285, 32'h1005, 32'h0305, 32'h0285, 32'h0005};
		int          add [6] = '{0, 1, 2, 0, 2, 2};
		int          n;
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, 32'h0, cfgs[i]);
			pad_src <= 1'b0;
			clk_src <= 1'b1;
			repeat (8) @(posedge CLK);
			pad_src <= 1'b1;
			n = 0;
			while (INPUT_PATH_FIRST !== 1'b1 && n < 20) begin
				@(posedge CLK);
				#1;
				n++;
			end
			// Pad model one edge, transparent latch one edge, path register one edge
			check(32'(n), 32'(3 + add[i]));
		end
		bus(1'b1, 32'h0, 32'h1505);
		bus(1'b0, 32'h4, 32'h0);
		check({30'h0, rd[6:5]}, {30'h0, io_capture_pkg::MEDIUM_INPUT_DELAY});
		$display("delay done");
	endtask
	initial begin
		repeat (5000) @(posedge CLK);
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		test_regs;
		test_modes;
		test_enable;
		test_delay;
		report_and_stop;
	end
endmodule // io_input_capture_path_test
